//--- src/upk_pkg.sv
package upk_pkg;
  // Command byte fields
  localparam logic [1:0] CMD_IDLE = 2'h0;
  localparam logic [1:0] CMD_TX = 2'h1;
  localparam logic [1:0] CMD_WR = 2'h2;
  localparam logic [1:0] CMD_RD = 2'h3;
  localparam logic [5:0] ADDR_EXT = 6'h2f;
  localparam logic [7:0] BYTE_IDLE = 8'h00;
  // Register array addresses
  localparam logic [7:0] ADR_FUNC = 8'h04;
  localparam logic [7:0] ADR_OTG = 8'h0a;
  localparam logic [7:0] ADR_STAT = 8'h13;
  localparam logic [7:0] ADR_IOPM = 8'h39;
  // Reset values
  localparam logic [7:0] FUNC_RST = 8'h00;
  localparam logic [7:0] OTG_RST = 8'h00;
  localparam logic [7:0] IOPM_RST = 8'h00;
  // Field positions
  localparam int FUNC_UART_BIT = 3;
  localparam int FUNC_LPM_BIT = 6;
  localparam int OTG_PULLDOWN_BIT = 3;
  localparam int OTG_PULLUP_BIT = 4;
  localparam int OTG_DRV_INT_BIT = 5;
  localparam int OTG_DRV_EXT_BIT = 6;
  localparam int IOPM_LVL_LO = 1;
  localparam int IOPM_LVL_HI = 2;
  localparam int IOPM_DP_PU_BIT = 4;
  localparam int IOPM_DM_PU_BIT = 5;
  localparam int LP_INT_BIT = 3;
  localparam logic [1:0] REG_LEVEL_USB = 2'h0;
  // Receive end latency
  localparam int RX_END_MAX_HS = 43;
  localparam int RX_END_LIMIT_HS = 63;
  // Phy end states
  typedef enum logic [3:0] {
    PS_START, PS_IDLE, PS_ACK, PS_EXT, PS_WDATA, PS_WSTP, PS_TX,
    PS_RTURN, PS_RDATA, PS_RXCMD, PS_RXC2, PS_RX, PS_LPM
  } upk_phy_st_e;
  // Link end states
  typedef enum logic [2:0] {
    LS_IDLE, LS_CMD, LS_HOLD, LS_WDATA, LS_RWAIT, LS_TX
  } upk_link_st_e;
endpackage : upk_pkg

//--- src/upk_ulpi_if.sv
interface upk_ulpi_if;
  logic clk_run;
  logic dir;
  logic nxt;
  logic stp;
  logic [7:0] phy_data;
  logic phy_oe;
  logic [7:0] link_data;
  logic link_oe;
  logic [7:0] bus;

  // Resolved bus level; an undriven bus reads as idle
  assign bus = phy_oe ? phy_data : (link_oe ? link_data : 8'h00);

  modport phy (
    output clk_run, dir, nxt, phy_data, phy_oe,
    input stp, bus
  );
  modport link (
    output stp, link_data, link_oe,
    input clk_run, dir, nxt, bus
  );
endinterface : upk_ulpi_if

//--- src/upk_phy_end.sv
// Operation
// - Discharge pull-down follows OTG bit 3
// - Charge pull-up follows OTG bit 4
// - Pump enable is OR of drive bits
// - Drive bits clear at reset
// - UART mode: regulator level, no linestate
// - Charger pull-ups off in reset, else bits
// - All pins on rising edge, clock indicated
// - Dir high to send, low to listen
// - Dir high while unable to accept
// - Link pulses stop one cycle to end
// - Next asserted on accept, link advances
// - Nonzero byte starts transfer, zero idle
// - One turn-around cycle on dir change
// - Low power: clock off, linestate on bus
// - Low power: interrupt on status change
// - Stop ends transfers and wakes device
// - Receive end delivered with low latency
// - Commands go to transmitter or registers
// - Top two bits select command type
// - Link drives idle after register write
// - Status change takes bus, sends status
//
// Chosen here: strobed register access and the register addresses.
module upk_phy_end (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Link side
  upk_ulpi_if.phy ulpi,
  // Analog status pins
  input wire logic [1:0] line_state_pin,
  input wire logic vbus_valid_pin,
  input wire logic id_gnd_pin,
  input wire logic pll_locked_pin,
  // USB receiver
  input wire logic rx_active,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  // USB transmitter
  output logic [7:0] tx_byte,
  output logic tx_valid,
  output logic tx_end,
  // OTG and power controls
  output logic vbus_pulldown_en,
  output logic vbus_pullup_en,
  output logic charge_pump_enable_out,
  output logic [1:0] uart_regulator_level,
  output logic dp_charger_pullup_en,
  output logic dm_charger_pullup_en
);
  upk_pkg::upk_phy_st_e state_r;
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  logic [3:0] stat_prev_r;
  logic dir_r;
  logic dir_d1_r;
  logic nxt_r;
  logic clk_run_r;
  logic [7:0] dout_r;
  logic [7:0] cmd_r;
  logic [7:0] addr_r;
  logic [7:0] wdata_r;
  logic [7:0] func_r;
  logic [7:0] otg_r;
  logic [7:0] iopm_r;
  logic evt_pend_r;
  logic lp_int_r;

  // Synchronised pins and derived decode
  wire [1:0] ls = pin_s2_r[1:0];
  wire vbus = pin_s2_r[2];
  wire id_gnd = pin_s2_r[3];
  wire pll_ok = pin_s2_r[4];
  wire stat_chg = pin_s2_r[3:0] != stat_prev_r;
  wire in_lpm = state_r == upk_pkg::PS_LPM;
  wire uart_on = func_r[upk_pkg::FUNC_UART_BIT];
  wire bus_ok = ~dir_r & ~dir_d1_r;
  wire cmd_nz = ulpi.bus != upk_pkg::BYTE_IDLE;
  wire [1:0] cmd_type = cmd_r[7:6];
  wire cmd_ext = cmd_r[5:0] == upk_pkg::ADDR_EXT;
  wire wr_fire = (state_r == upk_pkg::PS_WSTP) & ulpi.stp;
  wire lpm_exit = in_lpm & ulpi.stp;
  wire wr_func = addr_r == upk_pkg::ADR_FUNC;
  wire to_lpm = wr_func & (wdata_r[upk_pkg::FUNC_LPM_BIT] |
                           wdata_r[upk_pkg::FUNC_UART_BIT]);
  wire [7:0] rxcmd = {1'b0, id_gnd, 1'b0, rx_active, 1'b0, vbus, ls};
  wire [1:0] lp_lines = uart_on ? 2'h0 : ls;
  wire [7:0] lpm_byte = {4'h0, lp_int_r, 1'b0, lp_lines};
  wire [7:0] stat_val = {4'h0, id_gnd, vbus, ls};
  wire [7:0] rd_val = (addr_r == upk_pkg::ADR_FUNC) ? func_r :
                      (addr_r == upk_pkg::ADR_OTG) ? otg_r :
                      (addr_r == upk_pkg::ADR_IOPM) ? iopm_r :
                      (addr_r == upk_pkg::ADR_STAT) ? stat_val :
                      upk_pkg::BYTE_IDLE;

  // Pin outputs, all from flops on the rising edge
  assign ulpi.dir = dir_r;
  assign ulpi.nxt = nxt_r;
  assign ulpi.clk_run = clk_run_r;
  assign ulpi.phy_data = dout_r;
  assign ulpi.phy_oe = dir_r & dir_d1_r;

  // Two-flop synchronisers for analog and PLL pins
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_s1_r <= 5'h00;
      pin_s2_r <= 5'h00;
      stat_prev_r <= 4'h0;
    end else begin
      pin_s1_r <= {pll_locked_pin, id_gnd_pin, vbus_valid_pin,
                   line_state_pin};
      pin_s2_r <= pin_s1_r;
      stat_prev_r <= pin_s2_r[3:0];
    end
  end

  // Turn-around tracking
  always_ff @(posedge mclk) begin
    if (rst) begin
      dir_d1_r <= 1'b1;
    end else begin
      dir_d1_r <= dir_r;
    end
  end

  // Bus protocol state machine
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= upk_pkg::PS_START;
      dir_r <= 1'b1;
      nxt_r <= 1'b0;
      clk_run_r <= 1'b1;
      dout_r <= upk_pkg::BYTE_IDLE;
      cmd_r <= upk_pkg::BYTE_IDLE;
      addr_r <= upk_pkg::BYTE_IDLE;
      wdata_r <= upk_pkg::BYTE_IDLE;
    end else if (~pll_ok & ~in_lpm) begin
      state_r <= upk_pkg::PS_START;
      dir_r <= 1'b1;
      nxt_r <= 1'b0;
    end else begin
      case (state_r)
        upk_pkg::PS_START: begin
          dir_r <= 1'b0;
          state_r <= upk_pkg::PS_IDLE;
        end
        upk_pkg::PS_IDLE: begin
          if (rx_active) begin
            dir_r <= 1'b1;
            state_r <= upk_pkg::PS_RX;
          end else if (evt_pend_r) begin
            dir_r <= 1'b1;
            state_r <= upk_pkg::PS_RXCMD;
          end else if (bus_ok & cmd_nz) begin
            cmd_r <= ulpi.bus;
            addr_r <= {2'h0, ulpi.bus[5:0]};
            nxt_r <= 1'b1;
            state_r <= upk_pkg::PS_ACK;
          end
        end
        upk_pkg::PS_ACK: begin
          if (cmd_type == upk_pkg::CMD_TX) begin
            state_r <= upk_pkg::PS_TX;
          end else if (cmd_type == upk_pkg::CMD_IDLE) begin
            nxt_r <= 1'b0;
            state_r <= upk_pkg::PS_IDLE;
          end else if (cmd_ext) begin
            state_r <= upk_pkg::PS_EXT;
          end else if (cmd_type == upk_pkg::CMD_WR) begin
            state_r <= upk_pkg::PS_WDATA;
          end else begin
            nxt_r <= 1'b0;
            dir_r <= 1'b1;
            state_r <= upk_pkg::PS_RTURN;
          end
        end
        upk_pkg::PS_EXT: begin
          addr_r <= ulpi.bus;
          if (cmd_type == upk_pkg::CMD_WR) begin
            state_r <= upk_pkg::PS_WDATA;
          end else begin
            nxt_r <= 1'b0;
            dir_r <= 1'b1;
            state_r <= upk_pkg::PS_RTURN;
          end
        end
        upk_pkg::PS_WDATA: begin
          wdata_r <= ulpi.bus;
          nxt_r <= 1'b0;
          state_r <= upk_pkg::PS_WSTP;
        end
        upk_pkg::PS_WSTP: begin
          // Data commits only once stop arrives
          if (ulpi.stp & to_lpm) begin
            dir_r <= 1'b1;
            clk_run_r <= 1'b0;
            state_r <= upk_pkg::PS_LPM;
          end else if (ulpi.stp) begin
            state_r <= upk_pkg::PS_IDLE;
          end
        end
        upk_pkg::PS_TX: begin
          if (ulpi.stp) begin
            nxt_r <= 1'b0;
            state_r <= upk_pkg::PS_IDLE;
          end
        end
        upk_pkg::PS_RTURN: begin
          dout_r <= rd_val;
          state_r <= upk_pkg::PS_RDATA;
        end
        upk_pkg::PS_RXCMD: begin
          dout_r <= rxcmd;
          state_r <= upk_pkg::PS_RXC2;
        end
        upk_pkg::PS_RDATA, upk_pkg::PS_RXC2: begin
          dir_r <= 1'b0;
          state_r <= upk_pkg::PS_IDLE;
        end
        upk_pkg::PS_RX: begin
          dout_r <= rx_valid ? rx_byte : rxcmd;
          nxt_r <= rx_valid;
          if (~rx_active) begin
            // Bus released the cycle after receive ends
            nxt_r <= 1'b0;
            dir_r <= 1'b0;
            state_r <= upk_pkg::PS_IDLE;
          end
        end
        upk_pkg::PS_LPM: begin
          dout_r <= lpm_byte;
          if (ulpi.stp) begin
            dir_r <= 1'b0;
            clk_run_r <= 1'b1;
            state_r <= upk_pkg::PS_IDLE;
          end
        end
        default: begin
          state_r <= upk_pkg::PS_START;
        end
      endcase
    end
  end

  // Pending status byte; a new event beats the clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      evt_pend_r <= 1'b0;
    end else if ((stat_chg & ~in_lpm) | lpm_exit |
                 ((state_r == upk_pkg::PS_START) & pll_ok)) begin
      evt_pend_r <= 1'b1;
    end else if (state_r == upk_pkg::PS_RXC2) begin
      evt_pend_r <= 1'b0;
    end
  end

  // Low power interrupt, held until wake-up
  always_ff @(posedge mclk) begin
    if (rst) begin
      lp_int_r <= 1'b0;
    end else if (in_lpm & stat_chg) begin
      lp_int_r <= 1'b1;
    end else if (~in_lpm) begin
      lp_int_r <= 1'b0;
    end
  end

  // Transmit byte stream toward the USB transmitter
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_byte <= upk_pkg::BYTE_IDLE;
      tx_valid <= 1'b0;
      tx_end <= 1'b0;
    end else begin
      tx_byte <= ulpi.bus;
      tx_valid <= ((state_r == upk_pkg::PS_ACK) &
                   (cmd_type == upk_pkg::CMD_TX)) |
                  ((state_r == upk_pkg::PS_TX) & ~ulpi.stp);
      tx_end <= (state_r == upk_pkg::PS_TX) & ulpi.stp;
    end
  end

  // Register array; wake-up clears the mode bits
  always_ff @(posedge mclk) begin
    if (rst) begin
      func_r <= upk_pkg::FUNC_RST;
      otg_r <= upk_pkg::OTG_RST;
      iopm_r <= upk_pkg::IOPM_RST;
    end else if (lpm_exit) begin
      func_r[upk_pkg::FUNC_LPM_BIT] <= 1'b0;
      func_r[upk_pkg::FUNC_UART_BIT] <= 1'b0;
    end else if (wr_fire) begin
      if (wr_func) func_r <= wdata_r;
      if (addr_r == upk_pkg::ADR_OTG) otg_r <= wdata_r;
      if (addr_r == upk_pkg::ADR_IOPM) iopm_r <= wdata_r;
    end
  end

  // Analog control outputs
  assign vbus_pulldown_en = otg_r[upk_pkg::OTG_PULLDOWN_BIT];
  assign vbus_pullup_en = otg_r[upk_pkg::OTG_PULLUP_BIT];
  assign charge_pump_enable_out = otg_r[upk_pkg::OTG_DRV_INT_BIT] |
                                  otg_r[upk_pkg::OTG_DRV_EXT_BIT];
  assign uart_regulator_level = uart_on ?
    iopm_r[upk_pkg::IOPM_LVL_HI:upk_pkg::IOPM_LVL_LO] :
    upk_pkg::REG_LEVEL_USB;
  // Gated by reset itself so pull-ups drop within the cycle
  assign dp_charger_pullup_en = iopm_r[upk_pkg::IOPM_DP_PU_BIT] & ~rst;
  assign dm_charger_pullup_en = iopm_r[upk_pkg::IOPM_DM_PU_BIT] & ~rst;
endmodule : upk_phy_end

//--- src/upk_link_end.sv
module upk_link_end (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Phy side
  upk_ulpi_if.link ulpi,
  // Register requests
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic reg_busy,
  output logic [7:0] reg_rdata,
  output logic reg_rdata_valid,
  // Transmit stream
  input wire logic [7:0] tx_byte,
  input wire logic tx_last,
  input wire logic tx_valid,
  output logic tx_ready,
  // Receive stream and status bytes
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic rxcmd_valid,
  // Wake request
  input wire logic wake
);
  upk_pkg::upk_link_st_e state_r;
  logic [7:0] dout_r;
  logic stp_r;
  logic dir_d1_r;
  logic [7:0] ext_r;
  logic ext_need_r;
  logic is_wr_r;
  logic [7:0] wdata_r;
  logic last_r;

  // Ownership and handshake decode
  wire drive_ok = ~ulpi.dir & ~dir_d1_r;
  wire phy_data_ok = ulpi.dir & dir_d1_r & ulpi.clk_run;
  wire idle_st = state_r == upk_pkg::LS_IDLE;
  wire req = reg_wr | reg_rd;
  wire long_adr = (reg_addr[7:6] != 2'h0) |
                  (reg_addr[5:0] == upk_pkg::ADDR_EXT);
  wire [5:0] short_adr = long_adr ? upk_pkg::ADDR_EXT : reg_addr[5:0];
  wire [1:0] req_cmd = reg_wr ? upk_pkg::CMD_WR : upk_pkg::CMD_RD;
  wire tx_first = idle_st & drive_ok & ~req;
  wire tx_more = (state_r == upk_pkg::LS_TX) & ulpi.nxt & ~ulpi.dir &
                 ~last_r;
  wire rx_take = phy_data_ok & (state_r != upk_pkg::LS_RWAIT);

  assign tx_ready = tx_first | tx_more;
  assign reg_busy = ~idle_st | ~drive_ok;
  assign ulpi.link_data = dout_r;
  assign ulpi.link_oe = drive_ok;
  assign ulpi.stp = stp_r;

  // Turn-around tracking
  always_ff @(posedge mclk) begin
    if (rst) begin
      dir_d1_r <= 1'b1;
    end else begin
      dir_d1_r <= ulpi.dir;
    end
  end

  // Request sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= upk_pkg::LS_IDLE;
      dout_r <= upk_pkg::BYTE_IDLE;
      stp_r <= 1'b0;
      ext_r <= upk_pkg::BYTE_IDLE;
      ext_need_r <= 1'b0;
      is_wr_r <= 1'b0;
      wdata_r <= upk_pkg::BYTE_IDLE;
      last_r <= 1'b0;
      reg_rdata <= upk_pkg::BYTE_IDLE;
      reg_rdata_valid <= 1'b0;
    end else begin
      // One-cycle stop to wake a sleeping phy
      // Own last value masks a second cycle while wake is still high
      stp_r <= ulpi.dir & ~ulpi.clk_run & wake & ~stp_r;
      reg_rdata_valid <= 1'b0;
      case (state_r)
        upk_pkg::LS_IDLE: begin
          dout_r <= upk_pkg::BYTE_IDLE;
          if (drive_ok & req) begin
            dout_r <= {req_cmd, short_adr};
            ext_r <= reg_addr;
            ext_need_r <= long_adr;
            is_wr_r <= reg_wr;
            wdata_r <= reg_wdata;
            state_r <= upk_pkg::LS_CMD;
          end else if (drive_ok & tx_valid) begin
            dout_r <= {upk_pkg::CMD_TX, 2'h0, tx_byte[3:0]};
            last_r <= tx_last;
            state_r <= upk_pkg::LS_TX;
          end
        end
        upk_pkg::LS_CMD: begin
          if (ulpi.dir) begin
            // Phy grabbed the bus first; command is reissued
            state_r <= upk_pkg::LS_HOLD;
          end else if (ulpi.nxt & ext_need_r) begin
            dout_r <= ext_r;
            ext_need_r <= 1'b0;
          end else if (ulpi.nxt & is_wr_r) begin
            dout_r <= wdata_r;
            state_r <= upk_pkg::LS_WDATA;
          end else if (ulpi.nxt) begin
            dout_r <= upk_pkg::BYTE_IDLE;
            state_r <= upk_pkg::LS_RWAIT;
          end
        end
        upk_pkg::LS_HOLD: begin
          if (drive_ok) state_r <= upk_pkg::LS_CMD;
        end
        upk_pkg::LS_WDATA: begin
          if (ulpi.nxt) begin
            dout_r <= upk_pkg::BYTE_IDLE;
            stp_r <= 1'b1;
            state_r <= upk_pkg::LS_IDLE;
          end
        end
        upk_pkg::LS_RWAIT: begin
          if (phy_data_ok) begin
            reg_rdata <= ulpi.bus;
            reg_rdata_valid <= 1'b1;
            state_r <= upk_pkg::LS_IDLE;
          end
        end
        upk_pkg::LS_TX: begin
          if (ulpi.dir) begin
            state_r <= upk_pkg::LS_IDLE;
          end else if (ulpi.nxt & (last_r | ~tx_valid)) begin
            // Underrun also ends the packet
            dout_r <= upk_pkg::BYTE_IDLE;
            stp_r <= 1'b1;
            state_r <= upk_pkg::LS_IDLE;
          end else if (ulpi.nxt) begin
            dout_r <= tx_byte;
            last_r <= tx_last;
          end
        end
        default: begin
          state_r <= upk_pkg::LS_IDLE;
        end
      endcase
    end
  end

  // Receive data and status bytes from the phy
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_byte <= upk_pkg::BYTE_IDLE;
      rx_valid <= 1'b0;
      rxcmd_valid <= 1'b0;
    end else begin
      if (phy_data_ok) rx_byte <= ulpi.bus;
      rx_valid <= rx_take & ulpi.nxt;
      rxcmd_valid <= rx_take & ~ulpi.nxt;
    end
  end
endmodule : upk_link_end

//--- test/upk_chk.sv
module upk_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bus control
  input wire logic clk_run,
  input wire logic dir,
  input wire logic nxt,
  input wire logic stp,
  // Bus drive and level
  input wire logic phy_oe,
  input wire logic link_oe,
  input wire logic [7:0] bus
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Fresh command: link owns bus, idle before, not mid-stream
  sequence s_cmd;
    !dir && !$past(dir) && !$past(nxt) && $past(bus) == 8'h00 &&
      bus != 8'h00;
  endsequence
  sequence s_rd_imm;
    s_cmd ##0 (bus[7:6] == upk_pkg::CMD_RD &&
      bus[5:0] != upk_pkg::ADDR_EXT);
  endsequence
  sequence s_wr_imm;
    s_cmd ##0 (bus[7:6] == upk_pkg::CMD_WR &&
      bus[5:0] != upk_pkg::ADDR_EXT);
  endsequence
  // Read answer: turn, phy drives value, hands bus back
  sequence s_rd_turn;
    (dir && !nxt) ##1 phy_oe ##1 !dir;
  endsequence
  // Write end: stop with idle, then idle again
  sequence s_wr_end;
    ##1 (stp && bus == 8'h00) ##1 (!stp && (dir || bus == 8'h00));
  endsequence

  a_cmd_answer: assert property (s_cmd |=> nxt || dir)
    else $error("command byte not answered");
  a_read_turn: assert property (s_rd_imm ##1 nxt |=> s_rd_turn)
    else $error("register read turn-around wrong");
  a_write_stop: assert property (s_wr_imm ##1 nxt |=> s_wr_end)
    else $error("register write not closed by stop and idle");
  a_turn_quiet: assert property ($changed(dir) |-> !phy_oe && !link_oe)
    else $error("bus driven in turn-around cycle");
  a_phy_owner: assert property (phy_oe |-> dir && $past(dir))
    else $error("phy drives bus without owning it");
  a_link_owner: assert property (link_oe |-> !dir && !$past(dir))
    else $error("link drives bus while phy owns it");
  a_stop_pulse: assert property (stp |=> !stp)
    else $error("stop longer than one cycle");
  a_lp_dir: assert property (!clk_run |-> dir)
    else $error("direction low in low power");
  a_lp_bus: assert property (!clk_run |-> bus[7:4] == 4'h0 && !bus[2])
    else $error("low power bus pattern wrong");
endmodule : upk_chk

//--- test/tb_ulpi_phy_bus_and_otg_controls.sv
module tb_ulpi_phy_bus_and_otg_controls;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  // Phy pins and outputs
  logic [1:0] line_state_pin = 2'h0;
  logic vbus_valid_pin = 1'b0;
  logic id_gnd_pin = 1'b0;
  logic pll_locked_pin = 1'b0;
  logic [7:0] ph_tx_byte;
  logic ph_tx_valid;
  logic ph_tx_end;
  logic vbus_pulldown_en;
  logic vbus_pullup_en;
  logic charge_pump_enable_out;
  logic [1:0] uart_regulator_level;
  logic dp_charger_pullup_en;
  logic dm_charger_pullup_en;
  // Link user side
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic reg_busy;
  logic [7:0] reg_rdata;
  logic reg_rdata_valid;
  logic [7:0] lk_tx_byte = 8'h00;
  logic lk_tx_last = 1'b0;
  logic lk_tx_valid = 1'b0;
  logic lk_tx_ready;
  logic [7:0] lk_rx_byte;
  logic lk_rx_valid;
  logic lk_rxcmd_valid;
  logic wake = 1'b0;
  // Receiver inputs of the phy
  logic ph_rx_active = 1'b0;
  logic ph_rx_valid = 1'b0;
  logic [7:0] ph_rx_byte = 8'h00;
  logic [7:0] rx_seen[$];
  // Bench state
  int miscompares = 0;
  int n_tests = 0;
  int seed = 50;
  int n_end = 0;
  logic [7:0] last_rxcmd = 8'h00;
  logic [7:0] tx_seen[$];
  logic [7:0] corner[4] = '{8'h08, 8'h10, 8'h20, 8'h40};

  always #25 mclk = ~mclk;

  upk_ulpi_if u_if ();
  // Receiver inputs come straight from the bench
  upk_phy_end i_upk_phy_end (.mclk(mclk), .rst(rst), .ulpi(u_if.phy),
    .line_state_pin(line_state_pin), .vbus_valid_pin(vbus_valid_pin),
    .id_gnd_pin(id_gnd_pin), .pll_locked_pin(pll_locked_pin),
    .rx_active(ph_rx_active), .rx_valid(ph_rx_valid),
    .rx_byte(ph_rx_byte),
    .tx_byte(ph_tx_byte), .tx_valid(ph_tx_valid), .tx_end(ph_tx_end),
    .vbus_pulldown_en(vbus_pulldown_en), .vbus_pullup_en(vbus_pullup_en),
    .charge_pump_enable_out(charge_pump_enable_out),
    .uart_regulator_level(uart_regulator_level),
    .dp_charger_pullup_en(dp_charger_pullup_en),
    .dm_charger_pullup_en(dm_charger_pullup_en));
  upk_link_end i_upk_link_end (.mclk(mclk), .rst(rst), .ulpi(u_if.link),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_busy(reg_busy), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .tx_byte(lk_tx_byte),
    .tx_last(lk_tx_last), .tx_valid(lk_tx_valid), .tx_ready(lk_tx_ready),
    .rx_byte(lk_rx_byte), .rx_valid(lk_rx_valid),
    .rxcmd_valid(lk_rxcmd_valid), .wake(wake));
  upk_chk i_upk_chk (.mclk(mclk), .rst(rst), .clk_run(u_if.clk_run),
    .dir(u_if.dir), .nxt(u_if.nxt), .stp(u_if.stp), .phy_oe(u_if.phy_oe),
    .link_oe(u_if.link_oe), .bus(u_if.bus));

  // Capture status bytes and transmitter output
  always @(posedge mclk) begin
    if (lk_rxcmd_valid === 1'b1) last_rxcmd <= lk_rx_byte;
    if (ph_tx_valid === 1'b1) tx_seen.push_back(ph_tx_byte);
    if (ph_tx_end === 1'b1) n_end++;
    if (lk_rx_valid === 1'b1) rx_seen.push_back(lk_rx_byte);
  end

  function automatic logic [7:0] exp_rxcmd(input logic [1:0] ls,
    input logic vb, input logic id);
    return {1'b0, id, 3'h0, vb, ls};
  endfunction : exp_rxcmd

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic results();
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // Busy may rise a cycle late, so let a few edges pass first
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (3) @(posedge mclk);
    while (reg_busy !== 1'b0 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    check({7'h0, reg_busy}, 8'h00);
    // One more edge so a commit on the last edge is visible
    @(posedge mclk);
  endtask : wait_idle

  // Request held until an edge samples busy low
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d,
    input bit wt);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    do @(posedge mclk); while (reg_busy !== 1'b0);
    reg_wr <= 1'b0;
    if (wt) wait_idle();
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    int n;
    reg_addr <= a;
    reg_rd <= 1'b1;
    do @(posedge mclk); while (reg_busy !== 1'b0);
    reg_rd <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (reg_rdata_valid !== 1'b1 && n < 50);
    d = reg_rdata;
    wait_idle();
  endtask : reg_read

  task automatic wake_up();
    wake <= 1'b1;
    do @(posedge mclk); while (u_if.clk_run !== 1'b1);
    wake <= 1'b0;
    wait_idle();
  endtask : wake_up

  initial begin
    logic [7:0] d;
    logic [7:0] r;
    logic [7:0] v;
    logic [7:0] pk[4];
    repeat (20) @(posedge mclk);
    check({7'h0, charge_pump_enable_out}, 8'h00);
    rst <= 1'b0;
    repeat (10) @(posedge mclk);
    check({7'h0, u_if.dir}, 8'h01);
    pll_locked_pin <= 1'b1;
    wait_idle();
    check(last_rxcmd, exp_rxcmd(2'h0, 1'b0, 1'b0));
    // Pin changes while idle produce status bytes
    for (int i = 0; i < 3; i++) begin
      v = 8'($random(seed));
      line_state_pin <= v[1:0];
      vbus_valid_pin <= v[2];
      id_gnd_pin <= v[3];
      repeat (8) @(posedge mclk);
      wait_idle();
      check(last_rxcmd, exp_rxcmd(v[1:0], v[2], v[3]));
      reg_read(upk_pkg::ADR_STAT, r);
      check(r, {4'h0, v[3], v[2], v[1:0]});
    end
    // OTG controls: single bits first, then random
    for (int i = 0; i < 8; i++) begin
      d = (i < 4) ? corner[i] : 8'($random(seed));
      reg_write(upk_pkg::ADR_OTG, d, 1'b1);
      check({7'h0, vbus_pulldown_en}, {7'h0, d[3]});
      check({7'h0, vbus_pullup_en}, {7'h0, d[4]});
      check({7'h0, charge_pump_enable_out}, {7'h0, d[5] | d[6]});
      reg_read(upk_pkg::ADR_OTG, r);
      check(r, d);
    end
    // IOPM register by immediate address, then unmapped place
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed)) & 8'h36;
      reg_write(upk_pkg::ADR_IOPM, d, 1'b1);
      reg_read(upk_pkg::ADR_IOPM, r);
      check(r, d);
      check({7'h0, dp_charger_pullup_en}, {7'h0, d[4]});
      check({7'h0, dm_charger_pullup_en}, {7'h0, d[5]});
      check({6'h0, uart_regulator_level}, 8'h00);
    end
    reg_write(8'h20, 8'h5a, 1'b1);
    reg_read(8'h20, r);
    check(r, 8'h00);
    // Reset in mid-run: pull-ups drop before the edge
    reg_write(upk_pkg::ADR_OTG, 8'h60, 1'b1);
    reg_write(upk_pkg::ADR_IOPM, 8'h30, 1'b1);
    rst <= 1'b1;
    #1;
    check({6'h0, dp_charger_pullup_en, dm_charger_pullup_en}, 8'h00);
    @(posedge mclk);
    #1;
    check({7'h0, charge_pump_enable_out}, 8'h00);
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    wait_idle();
    // One packet through the transmitter
    for (int i = 0; i < 4; i++) begin
      pk[i] = (i == 0) ? 8'hc3 : 8'($random(seed));
      lk_tx_byte <= pk[i];
      lk_tx_last <= (i == 3);
      lk_tx_valid <= 1'b1;
      do @(posedge mclk); while (lk_tx_ready !== 1'b1);
    end
    lk_tx_valid <= 1'b0;
    lk_tx_last <= 1'b0;
    wait_idle();
    check(8'(tx_seen.size()), 8'h04);
    check(8'(n_end), 8'h01);
    check({4'h0, tx_seen[0][3:0]}, 8'h03);
    for (int i = 1; i < 4; i++) check(tx_seen[i], pk[i]);
    // Receive: turn, one status byte, then three data bytes
    ph_rx_active <= 1'b1;
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 3; i++) begin
      pk[i] = 8'($random(seed));
      ph_rx_byte <= pk[i];
      ph_rx_valid <= 1'b1;
      @(posedge mclk);
    end
    ph_rx_valid <= 1'b0;
    ph_rx_active <= 1'b0;
    wait_idle();
    check(8'(rx_seen.size()), 8'h03);
    for (int i = 0; i < 3; i++) check(rx_seen[i], pk[i]);
    check(last_rxcmd, 8'h10 | exp_rxcmd(v[1:0], v[2], v[3]));
    // Low power: line state on bus, change flagged, wake
    line_state_pin <= 2'h2;
    repeat (8) @(posedge mclk);
    wait_idle();
    reg_write(upk_pkg::ADR_FUNC, 8'h40, 1'b0);
    repeat (20) @(posedge mclk);
    check({7'h0, u_if.clk_run}, 8'h00);
    check({6'h0, u_if.bus[1:0]}, 8'h02);
    line_state_pin <= 2'h1;
    repeat (8) @(posedge mclk);
    check({6'h0, u_if.bus[3], u_if.bus[0]}, 8'h03);
    wake_up();
    check({7'h0, u_if.clk_run}, 8'h01);
    check(last_rxcmd, exp_rxcmd(2'h1, v[2], v[3]));
    // Uart mode switches the regulator level
    reg_write(upk_pkg::ADR_IOPM, 8'h04, 1'b1);
    reg_write(upk_pkg::ADR_FUNC, 8'h08, 1'b0);
    repeat (20) @(posedge mclk);
    check({6'h0, uart_regulator_level}, 8'h02);
    check({6'h0, u_if.bus[1:0]}, 8'h00);
    wake_up();
    check({6'h0, uart_regulator_level}, 8'h00);
    results();
  end

  // Whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    results();
  end
endmodule : tb_ulpi_phy_bus_and_otg_controls
